//--- verilog/sysconfig_pkg.sv
// Purpose: Shared constants for the bridge system configuration registers
// Assumes: Byte offsets in configuration space, dword-aligned access
// Notes: Field positions refer to the system setup control register
package sysconfig_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SUBSYS_VENDOR = 8'h40;
	localparam logic [7:0] OFS_SUBSYS = 8'h42;
	localparam logic [7:0] OFS_LEGACY_BASE = 8'h44;
	localparam logic [7:0] OFS_SYS_CTRL = 8'h80;
	// Reset values
	localparam logic [15:0] RST_SUBSYS_VENDOR = 16'h0000;
	localparam logic [15:0] RST_SUBSYS = 16'h0000;
	localparam logic [31:0] RST_LEGACY_BASE = 32'h00000001;
	localparam logic [31:0] RST_SYS_CTRL = 32'h00449060;
	// Writable bits of system control, status bit excluded
	localparam logic [31:0] SYS_CTRL_WMASK = 32'hCD7FC0FF;
	// System control field positions
	localparam int SLOT_STEP_HI = 31;
	localparam int SLOT_STEP_LO = 30;
	localparam int OSC_EN_BIT = 27;
	localparam int ROUTE_BIT = 26;
	localparam int PWR_FLAG_BIT = 25;
	localparam int PWR_EN_BIT = 24;
	localparam int SUBSYS_WE_BIT = 5;
endpackage

//--- verilog/legacy_port_decode.sv
// Purpose: Decodes the index and data I/O port pair of the legacy window
// Assumes: Base held by the register file, bit 0 forced to one there
// Notes: Index port sits on the word boundary, data port one above
`timescale 1ns/1ns
module legacy_port_decode (
	// Window base
	input wire logic [31:0] base_i,
	// I/O cycle
	input wire logic io_cycle_i,
	input wire logic [31:0] io_addr_i,
	// Port selects
	output logic index_sel_o,
	output logic data_sel_o
);
	logic [31:0] index_addr;

	// Word-aligned index address and its successor
	assign index_addr = {base_i[31:1], 1'b0};
	assign index_sel_o = io_cycle_i && (io_addr_i == index_addr); // R04
	assign data_sel_o = io_cycle_i &&
		(io_addr_i == (index_addr | 32'h00000001)); // R04
endmodule

//--- verilog/card_bridge_sysconfig_regs.sv
// Purpose: Subsystem identity, legacy window base and system control regs
// Assumes: Host configuration access port, one strobe per dword access
// Notes: Read data appears registered one cycle after the read strobe
`timescale 1ns/1ns
// Behaviour
// R01: Subsystem vendor identity at 40h, resets zero, reads back stored value.
// R02: Subsystem identity at 42h, resets zero, reads back stored value.
// R03: Both identity registers accept writes only while bit 5 is set.
// R04: Legacy base selects index port, base plus one selects data port.
// R05: Legacy base bits 31..1 writable, bit 0 always reads one.
// R06: Bits 31..30 pick serial interrupt slot A, B, C or D.
// R07: Control bits 29 and 28 ignore writes and read zero.
// R08: Bit 27 enables internal oscillator, reset leaves it off.
// R09: Bit 26 routes power-write interrupt to line two or status change.
// R10: Power-write flag sets when enable set and socket power written.
// R11: Writing one to bit 25 clears the flag; zero leaves it.
// R12: Bit 24 enables power-write interrupt signalling, resets to zero.
// R13: Whole system control register resets to 0044 9060h.
module card_bridge_sysconfig_regs (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	// Configuration access
	input wire logic CFG_WR_I,
	input wire logic CFG_RD_I,
	input wire logic [7:0] CFG_ADDR_I,
	input wire logic [3:0] CFG_BE_I,
	input wire logic [31:0] CFG_WDATA_I,
	output logic [31:0] CFG_RDATA_O,
	output logic CFG_ACK_O,
	// Legacy I/O window
	input wire logic IO_CYCLE_I,
	input wire logic [31:0] IO_ADDR_I,
	output logic INDEX_SEL_O,
	output logic DATA_SEL_O,
	// Socket power write event
	input wire logic POWER_WRITE_I,
	// System outputs
	output logic [1:0] SERIAL_IRQ_SLOT_STEP_O,
	output logic INTERNAL_OSC_ENABLE_O,
	output logic SUBSYSTEM_IDENT_WRITE_ENABLE_O,
	output logic LEGACY_IRQ_LINE_TWO_O,
	output logic CARD_STATUS_CHANGE_IRQ_O
);
	logic [15:0] vendor_q;
	logic [15:0] subsys_q;
	logic [31:0] base_q;
	logic [31:0] ctrl_q;
	logic flag_q;
	logic [31:0] ctrl_rd;
	logic [31:0] wmask;
	logic subsys_we;
	logic pwr_event;

	////////////////////////////////////////////////////////////////////////
	// Access helpers

	// Byte-enable mask expansion
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Dword hit test
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction

	assign wmask = be_mask(CFG_BE_I);
	assign subsys_we = ctrl_q[sysconfig_pkg::SUBSYS_WE_BIT];
	assign pwr_event = POWER_WRITE_I && ctrl_q[sysconfig_pkg::PWR_EN_BIT]; // R12
	// Reserved 29..28 zero, status bit from its own flop
	assign ctrl_rd = {ctrl_q[31:30], 2'b00, ctrl_q[27:26], flag_q,
		ctrl_q[24:0]}; // R07

	////////////////////////////////////////////////////////////////////////
	// Register updates

	// Subsystem vendor identity, gated by the write enable bit
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			vendor_q <= sysconfig_pkg::RST_SUBSYS_VENDOR; // R01
		end else if (CFG_WR_I && subsys_we &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_SUBSYS_VENDOR)) begin // R03
			vendor_q <= (vendor_q & ~wmask[15:0]) |
				(CFG_WDATA_I[15:0] & wmask[15:0]); // R01
		end
	end

	// Subsystem identity, upper half of the same dword
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			subsys_q <= sysconfig_pkg::RST_SUBSYS; // R02
		end else if (CFG_WR_I && subsys_we &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_SUBSYS)) begin // R03
			subsys_q <= (subsys_q & ~wmask[31:16]) |
				(CFG_WDATA_I[31:16] & wmask[31:16]); // R02
		end
	end

	// Legacy base, bit 0 held at one
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			base_q <= sysconfig_pkg::RST_LEGACY_BASE;
		end else if (CFG_WR_I &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_LEGACY_BASE)) begin
			base_q <= ((base_q & ~wmask) | (CFG_WDATA_I & wmask)) |
				32'h00000001; // R05
		end
	end

	// System control writable bits; read-only bits keep reset value
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			ctrl_q <= sysconfig_pkg::RST_SYS_CTRL & ~32'h02000000; // R13
		end else if (CFG_WR_I &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_SYS_CTRL)) begin
			ctrl_q <= (ctrl_q & ~(wmask & sysconfig_pkg::SYS_CTRL_WMASK)) |
				(CFG_WDATA_I & wmask & sysconfig_pkg::SYS_CTRL_WMASK); // R07
		end
	end

	// Power-write status flag, set wins over clear
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			flag_q <= 1'b0; // R11
		end else if (pwr_event) begin
			flag_q <= 1'b1; // R10
		end else if (CFG_WR_I && CFG_BE_I[3] &&
			CFG_WDATA_I[sysconfig_pkg::PWR_FLAG_BIT] &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_SYS_CTRL)) begin
			flag_q <= 1'b0; // R11
		end
	end

	// Interrupt requests, registered copies of the power-write event steered by the route bit
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			LEGACY_IRQ_LINE_TWO_O <= 1'b0;
			CARD_STATUS_CHANGE_IRQ_O <= 1'b0;
		end else begin
			LEGACY_IRQ_LINE_TWO_O <= pwr_event &&
				!ctrl_q[sysconfig_pkg::ROUTE_BIT]; // R09
			CARD_STATUS_CHANGE_IRQ_O <= pwr_event &&
				ctrl_q[sysconfig_pkg::ROUTE_BIT]; // R09
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Registered read data, unmapped offsets read zero
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			CFG_RDATA_O <= 32'h00000000;
			CFG_ACK_O <= 1'b0;
		end else begin
			CFG_ACK_O <= CFG_RD_I || CFG_WR_I;
			if (CFG_RD_I) begin
				if (hit(CFG_ADDR_I, sysconfig_pkg::OFS_SUBSYS_VENDOR)) begin
					CFG_RDATA_O <= {subsys_q, vendor_q}; // R01
				end else if (hit(CFG_ADDR_I,
					sysconfig_pkg::OFS_LEGACY_BASE)) begin
					CFG_RDATA_O <= base_q; // R05
				end else if (hit(CFG_ADDR_I, sysconfig_pkg::OFS_SYS_CTRL)) begin
					CFG_RDATA_O <= ctrl_rd;
				end else begin
					CFG_RDATA_O <= 32'h00000000;
				end
			end
		end
	end

	// Static control outputs
	always_ff @(posedge REF_CLK_I) begin
		if (!RESETN_I) begin
			SERIAL_IRQ_SLOT_STEP_O <= 2'b00;
			INTERNAL_OSC_ENABLE_O <= 1'b0;
			SUBSYSTEM_IDENT_WRITE_ENABLE_O <= 1'b0;
		end else begin
			SERIAL_IRQ_SLOT_STEP_O <= ctrl_q[sysconfig_pkg::SLOT_STEP_HI:
				sysconfig_pkg::SLOT_STEP_LO]; // R06
			INTERNAL_OSC_ENABLE_O <= ctrl_q[sysconfig_pkg::OSC_EN_BIT]; // R08
			SUBSYSTEM_IDENT_WRITE_ENABLE_O <= subsys_we;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Legacy port decode

	legacy_port_decode u_decode (
		.base_i(base_q),
		.io_cycle_i(IO_CYCLE_I),
		.io_addr_i(IO_ADDR_I),
		.index_sel_o(INDEX_SEL_O),
		.data_sel_o(DATA_SEL_O)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence ctrl_write_s;
		CFG_WR_I && hit(CFG_ADDR_I, sysconfig_pkg::OFS_SYS_CTRL);
	endsequence

	sequence sys_read_s;
		CFG_RD_I && hit(CFG_ADDR_I, sysconfig_pkg::OFS_SYS_CTRL);
	endsequence

	sequence ident_write_s;
		CFG_WR_I && !subsys_we &&
			hit(CFG_ADDR_I, sysconfig_pkg::OFS_SUBSYS_VENDOR);
	endsequence

	ident_locked_a: assert property (@(posedge REF_CLK_I) // R03
		disable iff (!RESETN_I)
		ident_write_s |=> $stable({subsys_q, vendor_q}))
		else $error("identity changed while write disabled");

	ident_reset_a: assert property (@(posedge REF_CLK_I) // R01
		!RESETN_I |=> vendor_q == 16'h0000 && subsys_q == 16'h0000)
		else $error("identity not cleared by reset");

	base_bit0_a: assert property (@(posedge REF_CLK_I) // R05
		disable iff (!RESETN_I)
		CFG_RD_I && hit(CFG_ADDR_I, sysconfig_pkg::OFS_LEGACY_BASE)
		|=> CFG_RDATA_O[0])
		else $error("legacy base bit 0 read as zero");

	port_pair_a: assert property (@(posedge REF_CLK_I) // R04
		disable iff (!RESETN_I)
		IO_CYCLE_I && IO_ADDR_I == {base_q[31:1], 1'b1} |-> DATA_SEL_O
		&& !INDEX_SEL_O)
		else $error("data port not selected at base plus one");

	rsvd_zero_a: assert property (@(posedge REF_CLK_I) // R07
		disable iff (!RESETN_I)
		sys_read_s |=> CFG_RDATA_O[29:28] == 2'b00)
		else $error("reserved control bits read nonzero");

	flag_set_a: assert property (@(posedge REF_CLK_I) // R10
		disable iff (!RESETN_I)
		pwr_event |=> flag_q)
		else $error("power-write flag not set");

	flag_clear_a: assert property (@(posedge REF_CLK_I) // R11
		disable iff (!RESETN_I)
		ctrl_write_s ##0 CFG_BE_I[3] && CFG_WDATA_I[25] && !pwr_event
		|=> !flag_q)
		else $error("power-write flag not cleared by one");

	irq_route_a: assert property (@(posedge REF_CLK_I) // R09
		disable iff (!RESETN_I)
		pwr_event |=> (LEGACY_IRQ_LINE_TWO_O == !$past(ctrl_q[26]))
		&& (CARD_STATUS_CHANGE_IRQ_O == $past(ctrl_q[26])))
		else $error("power-write interrupt misrouted");

	no_event_a: assert property (@(posedge REF_CLK_I) // R12
		disable iff (!RESETN_I)
		!ctrl_q[24] |=> !LEGACY_IRQ_LINE_TWO_O && !CARD_STATUS_CHANGE_IRQ_O)
		else $error("interrupt raised while disabled");

	osc_follow_a: assert property (@(posedge REF_CLK_I) // R08
		disable iff (!RESETN_I)
		ctrl_write_s ##0 CFG_BE_I[3] |=> ##1
		INTERNAL_OSC_ENABLE_O == $past(CFG_WDATA_I[27], 2))
		else $error("oscillator enable does not follow write");

	slot_follow_a: assert property (@(posedge REF_CLK_I) // R06
		disable iff (!RESETN_I)
		ctrl_write_s ##0 CFG_BE_I[3] |=> ##1
		SERIAL_IRQ_SLOT_STEP_O == $past(CFG_WDATA_I[31:30], 2))
		else $error("slot step does not follow write");

	ctrl_reset_a: assert property (@(posedge REF_CLK_I) // R13
		!RESETN_I |=> ctrl_rd == 32'h00449060)
		else $error("system control reset value wrong");
endmodule

//--- testbench/cfg_host_model.sv
// Purpose: Host model driving configuration, I/O and power-write events
// Assumes: Strobes are one-cycle pulses launched on the falling edge
// Notes: Tasks are called from the bench through this instance
`timescale 1ns/1ns
module cfg_host_model (
	// Clock
	input wire logic clk_i,
	// Configuration access
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [3:0] be_o,
	output logic [31:0] wdata_o,
	// I/O cycle and power event
	output logic io_cycle_o,
	output logic [31:0] io_addr_o,
	output logic pwr_o
);
	////////////////////////////////////////////////////////////////////////
	// Idle bus at time zero
	initial begin
		{wr_o, rd_o, addr_o, be_o, wdata_o} = '0;
		{io_cycle_o, io_addr_o, pwr_o} = '0;
	end

	// One config access, returns in the acknowledge cycle
	task automatic access(input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_i);
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		be_o = b;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
	endtask

	// Socket power write pulse, returns in the interrupt cycle
	task automatic pulse();
		@(negedge clk_i);
		pwr_o = 1'b1;
		@(negedge clk_i);
		pwr_o = 1'b0;
	endtask

	// I/O cycle, or none, at any address, not only the index/data pair
	task automatic io(input logic c, input logic [31:0] a);
		@(negedge clk_i);
		io_cycle_o = c;
		io_addr_o = a;
		#1;
	endtask
endmodule

//--- testbench/card_bridge_sysconfig_regs_bench.sv
// Purpose: Self-checking bench for the system configuration registers
// Assumes: Expected read data is queued by rd_exp in the bench and checked on ack
// Notes: Other outputs are compared directly after each event
`timescale 1ns/1ns
module card_bridge_sysconfig_regs_bench;
	logic clk, rst_n, wr, rd, ioc, pwr, was_rd, ack, isel, dsel;
	logic osc, we, lirq, cirq;
	logic [1:0] slot;
	logic [3:0] be;
	logic [7:0] addr;
	logic [31:0] wdata, ioa, rdata, r, c;
	logic [31:0] exp_q[$];
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock, design and host
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	card_bridge_sysconfig_regs i_dut (.REF_CLK_I(clk), .RESETN_I(rst_n),
		.CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_BE_I(be),
		.CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack),
		.IO_CYCLE_I(ioc), .IO_ADDR_I(ioa), .INDEX_SEL_O(isel),
		.DATA_SEL_O(dsel), .POWER_WRITE_I(pwr),
		.SERIAL_IRQ_SLOT_STEP_O(slot), .INTERNAL_OSC_ENABLE_O(osc),
		.SUBSYSTEM_IDENT_WRITE_ENABLE_O(we), .LEGACY_IRQ_LINE_TWO_O(lirq),
		.CARD_STATUS_CHANGE_IRQ_O(cirq));
	cfg_host_model i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.be_o(be), .wdata_o(wdata), .io_cycle_o(ioc), .io_addr_o(ioa),
		.pwr_o(pwr));

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict, read with expectation
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		i_host.access(1'b0, a, 4'hF, 32'h0);
	endtask

	// Read monitor and hang limit
	always @(posedge clk) begin
		was_rd <= rd;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end
	always @(negedge clk) begin
		if (ack === 1'b1 && was_rd === 1'b1 && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'hBF179540));
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		// Reset values, unmapped read
		rd_exp(8'h40, 32'h0);
		rd_exp(8'h42, 32'h0);
		rd_exp(8'h44, 32'h1);
		rd_exp(8'h80, 32'h00449060);
		rd_exp(8'h50, 32'h0);
		check(32'(we), 32'h1);
		// Identity writes locked, then unlocked
		i_host.access(1'b1, 8'h80, 4'hF, 32'h0);
		r = $urandom();
		i_host.access(1'b1, 8'h40, 4'hF, r);
		rd_exp(8'h40, 32'h0);
		rd_exp(8'h80, 32'h00001000);
		check(32'(we), 32'h0);
		i_host.access(1'b1, 8'h80, 4'hF, 32'h20);
		c = $urandom();
		i_host.access(1'b1, 8'h40, 4'h3, r);
		i_host.access(1'b1, 8'h42, 4'hC, c);
		rd_exp(8'h40, {c[31:16], r[15:0]});
		// Reserved and read-only bits
		i_host.access(1'b1, 8'h80, 4'hF, 32'hFFFFFFFF);
		rd_exp(8'h80, 32'hCD7FD0FF);
		// Slot step, oscillator, routing, flag set and clear
		for (int i = 0; i < 4; i++) begin
			c = {i[1:0], 2'b00, i[0], i[1], 2'b01, 24'h000020};
			i_host.access(1'b1, 8'h80, 4'hF, c);
			@(negedge clk);
			check(32'(slot), 32'(i[1:0]));
			check(32'(osc), 32'(i[0]));
			i_host.pulse();
			check(32'({lirq, cirq}), 32'({~i[1], i[1]}));
			rd_exp(8'h80, c | 32'h02001000);
			i_host.access(1'b1, 8'h80, 4'hF, c);
			rd_exp(8'h80, c | 32'h02001000);
			i_host.access(1'b1, 8'h80, 4'h8, c | 32'h02000000);
			rd_exp(8'h80, c | 32'h00001000);
		end
		// Enable clear blocks the event
		i_host.access(1'b1, 8'h80, 4'hF, 32'h20);
		i_host.pulse();
		check(32'({lirq, cirq}), 32'h0);
		rd_exp(8'h80, 32'h00001020);
		// Legacy window base and port decode
		r = $urandom();
		i_host.access(1'b1, 8'h44, 4'hF, r);
		rd_exp(8'h44, r | 32'h1);
		for (int k = 0; k < 4; k++) begin
			i_host.io(k != 3, {r[31:1], 1'b0} + 32'(k % 3));
			check(32'({isel, dsel}), 32'({k == 0, k == 1}));
		end
		// Mid-run reset puts written registers back to defaults
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd_exp(8'h40, 32'h0);
		rd_exp(8'h44, 32'h1);
		rd_exp(8'h80, 32'h00449060);
		check(32'(we), 32'h1);
		repeat (2) @(negedge clk);
		// Every queued read must have been answered
		check(32'(exp_q.size()), 32'h0);
		final_report();
	end
endmodule
